// >>> adcsr_host.sv
`timescale 1ns/1ps
module adcsr_host
    import adcsr_pkg::*;
(
    input wire logic clk,
    output adcsr_req_t req
);
    initial req = '0;
    // One decoded register command, held until the next op call
    task automatic op(input logic w, input logic r, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        req = '{w, r, a, d};
    endtask
endmodule // adcsr_host

// >>> adcsr_pkg.sv
package adcsr_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int         ADCSR_ADDR_W          = 5;
    localparam int         ADCSR_DATA_W          = 8;
    localparam logic [4:0] ADCSR_STATUS_ADDR     = 5'h01;
    localparam logic [4:0] ADCSR_INSEL_ADDR      = 5'h02;

    // ************************************************************
    // Status register fields
    // ************************************************************
    localparam int ADCSR_POR_BIT        = 7;
    localparam int ADCSR_NOT_READY_BIT  = 6;
    localparam int ADCSR_POS_TOP_BIT    = 5;
    localparam int ADCSR_POS_BOT_BIT    = 4;
    localparam int ADCSR_NEG_TOP_BIT    = 3;
    localparam int ADCSR_NEG_BOT_BIT    = 2;
    localparam int ADCSR_REF_THIRD_BIT  = 1;
    localparam int ADCSR_REF_MISS_BIT   = 0;

    localparam logic [7:0] ADCSR_STATUS_RESET = 8'h80;
    localparam logic       ADCSR_POR_RESET    = 1'h1;

    // ************************************************************
    // Input select register fields
    // ************************************************************
    localparam int         ADCSR_POS_SEL_LSB  = 4;
    localparam int         ADCSR_NEG_SEL_LSB  = 0;
    localparam int         ADCSR_SEL_W        = 4;
    localparam logic [3:0] ADCSR_POS_SEL_RESET = 4'h0;
    localparam logic [3:0] ADCSR_NEG_SEL_RESET = 4'h1;
    localparam logic [3:0] ADCSR_SEL_COMMON    = 4'hC;
    localparam logic [3:0] ADCSR_SEL_WIDE_LO   = 4'h6;
    localparam logic [3:0] ADCSR_SEL_WIDE_HI   = 4'hB;

    // ************************************************************
    // Monitor comparator inputs and sync defaults
    // ************************************************************
    localparam int        ADCSR_MON_W      = 7;
    localparam logic [6:0] ADCSR_MON_RESET = 7'h40;

    typedef struct packed {
        logic startup_done;
        logic pos_out_near_top_rail;
        logic pos_out_near_bottom_rail;
        logic neg_out_near_top_rail;
        logic neg_out_near_bottom_rail;
        logic reference_below_third_supply;
        logic reference_missing_flag;
    } adcsr_mon_t;

    typedef struct packed {
        logic                    wr_en;
        logic                    rd_en;
        logic [ADCSR_ADDR_W-1:0] addr;
        logic [ADCSR_DATA_W-1:0] wdata;
    } adcsr_req_t;

endpackage

// >>> adcsr_regs.sv
`timescale 1ns/1ps
module adcsr_regs
    import adcsr_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire adcsr_req_t              req,
    output logic      [ADCSR_DATA_W-1:0] rd_data,
    output logic                         rd_valid,
    input  wire adcsr_mon_t              mon_async,
    input  wire logic                    rail_monitor_enable,
    input  wire logic [1:0]              reference_monitor_enable,
    input  wire logic                    twelve_channel,
    output logic      [ADCSR_SEL_W-1:0]  positive_input_select,
    output logic      [ADCSR_SEL_W-1:0]  negative_input_select,
    output logic                         common_analog_input_pos,
    output logic                         common_analog_input_neg,
    output logic                         select_illegal
);

    // ************************************************************
    // Synchronised monitor inputs
    // ************************************************************
    adcsr_mon_t mon;

    adcsr_sync #(
        .WIDTH (ADCSR_MON_W),
        .INIT  (ADCSR_MON_RESET)
    ) u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (mon_async),
        .sync_out (mon)
    );

    // ************************************************************
    // Register state
    // ************************************************************
    logic                    por_flag_reg;
    logic                    por_flag_next;
    logic [6:0]              live_reg;
    logic [6:0]              live_next;
    logic [ADCSR_SEL_W-1:0]  pos_sel_reg;
    logic [ADCSR_SEL_W-1:0]  pos_sel_next;
    logic [ADCSR_SEL_W-1:0]  neg_sel_reg;
    logic [ADCSR_SEL_W-1:0]  neg_sel_next;
    logic [ADCSR_DATA_W-1:0] rd_data_reg;
    logic [ADCSR_DATA_W-1:0] rd_data_next;
    logic                    rd_valid_reg;
    logic                    rd_valid_next;
    logic                    illegal_reg;
    logic                    illegal_next;
    logic                    com_pos_reg;
    logic                    com_pos_next;
    logic                    com_neg_reg;
    logic                    com_neg_next;
    logic [ADCSR_DATA_W-1:0] status_view;

    function automatic logic sel_bad(input logic [ADCSR_SEL_W-1:0] code, input logic wide);
        logic bad;
        bad = (code > ADCSR_SEL_COMMON);
        if (!wide && code >= ADCSR_SEL_WIDE_LO && code <= ADCSR_SEL_WIDE_HI)
        begin
            bad = 1'b1;
        end
        return bad;
    endfunction

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb
    begin
        por_flag_next = por_flag_reg;
        pos_sel_next  = pos_sel_reg;
        neg_sel_next  = neg_sel_reg;

        // Live flags, each gated by its monitor enable except not-ready, which is never gated
        live_next[ADCSR_NOT_READY_BIT] = ~mon.startup_done;
        live_next[ADCSR_POS_TOP_BIT]   = rail_monitor_enable
                                         & mon.pos_out_near_top_rail;
        live_next[ADCSR_POS_BOT_BIT]   = rail_monitor_enable
                                         & mon.pos_out_near_bottom_rail;
        live_next[ADCSR_NEG_TOP_BIT]   = rail_monitor_enable
                                         & mon.neg_out_near_top_rail;
        live_next[ADCSR_NEG_BOT_BIT]   = rail_monitor_enable
                                         & mon.neg_out_near_bottom_rail;
        live_next[ADCSR_REF_THIRD_BIT] = reference_monitor_enable[1]
                                         & mon.reference_below_third_supply;
        live_next[ADCSR_REF_MISS_BIT]  = (reference_monitor_enable != 2'h0)
                                         & mon.reference_missing_flag;

        if (req.wr_en)
        begin
            unique case (req.addr)
                ADCSR_STATUS_ADDR:
                begin
                    por_flag_next = req.wdata[ADCSR_POR_BIT];
                end
                ADCSR_INSEL_ADDR:
                begin
                    pos_sel_next = req.wdata[ADCSR_POS_SEL_LSB +: ADCSR_SEL_W];
                    neg_sel_next = req.wdata[ADCSR_NEG_SEL_LSB +: ADCSR_SEL_W];
                end
                default:
                begin
                    por_flag_next = por_flag_reg;
                end
            endcase
        end

        // Read path, one cycle latency, unmapped reads give zero
        rd_valid_next = req.rd_en;
        rd_data_next  = 8'h00;
        if (req.rd_en)
        begin
            unique case (req.addr)
                ADCSR_STATUS_ADDR: rd_data_next = status_view;
                ADCSR_INSEL_ADDR:  rd_data_next = {pos_sel_reg, neg_sel_reg};
                default:           rd_data_next = 8'h00;
            endcase
        end

        illegal_next = sel_bad(pos_sel_reg, twelve_channel)
                     | sel_bad(neg_sel_reg, twelve_channel);
        com_pos_next = (pos_sel_reg == ADCSR_SEL_COMMON);
        com_neg_next = (neg_sel_reg == ADCSR_SEL_COMMON);
    end

    assign status_view = {por_flag_reg, live_reg};

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            por_flag_reg <= ADCSR_POR_RESET;
            live_reg     <= ADCSR_STATUS_RESET[6:0];
            pos_sel_reg  <= ADCSR_POS_SEL_RESET;
            neg_sel_reg  <= ADCSR_NEG_SEL_RESET;
            rd_data_reg  <= 8'h00;
            rd_valid_reg <= 1'b0;
            illegal_reg  <= 1'b0;
            com_pos_reg  <= 1'b0;
            com_neg_reg  <= 1'b0;
        end
        else
        begin
            por_flag_reg <= por_flag_next;
            live_reg     <= live_next;
            pos_sel_reg  <= pos_sel_next;
            neg_sel_reg  <= neg_sel_next;
            rd_data_reg  <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
            illegal_reg  <= illegal_next;
            com_pos_reg  <= com_pos_next;
            com_neg_reg  <= com_neg_next;
        end
    end

    assign rd_data                 = rd_data_reg;
    assign rd_valid                = rd_valid_reg;
    assign positive_input_select   = pos_sel_reg;
    assign negative_input_select   = neg_sel_reg;
    assign common_analog_input_pos = com_pos_reg;
    assign common_analog_input_neg = com_neg_reg;
    assign select_illegal          = illegal_reg;

endmodule // adcsr_regs

// >>> adcsr_regs_chk.sv
`timescale 1ns/1ps
module adcsr_regs_chk
    import adcsr_pkg::*;
(
    input wire logic                    clk,
    input wire logic                    rst_n,
    input wire adcsr_req_t              req,
    input wire logic [ADCSR_DATA_W-1:0] rd_data,
    input wire logic                    rd_valid,
    input wire logic                    rail_monitor_enable,
    input wire logic [1:0]              reference_monitor_enable,
    input wire logic                    twelve_channel,
    input wire logic [ADCSR_SEL_W-1:0]  positive_input_select,
    input wire logic [ADCSR_SEL_W-1:0]  negative_input_select,
    input wire logic                    common_analog_input_pos,
    input wire logic                    common_analog_input_neg,
    input wire logic                    select_illegal
);
    // ************************************************************
    // Register bank properties
    // ************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    function automatic logic bad(logic [3:0] c, logic t);
        return c > 4'hC || (!t && c >= 4'h6 && c <= 4'hB);
    endfunction
    sequence s_rd_st;
        req.rd_en && req.addr == ADCSR_STATUS_ADDR;
    endsequence
    sequence s_wr_st;
        req.wr_en && req.addr == ADCSR_STATUS_ADDR;
    endsequence
    property p_rd_ans; req.rd_en |=> rd_valid; endproperty
    property p_rd_idle; !req.rd_en |=> !rd_valid && rd_data == 8'h00; endproperty
    property p_pos;
        req.wr_en && req.addr == ADCSR_INSEL_ADDR |=> positive_input_select == $past(req.wdata[7:4]);
    endproperty
    property p_neg;
        req.wr_en && req.addr == ADCSR_INSEL_ADDR |=> negative_input_select == $past(req.wdata[3:0]);
    endproperty
    property p_hold;
        !(req.wr_en && req.addr == ADCSR_INSEL_ADDR) |=>
            $stable({positive_input_select, negative_input_select});
    endproperty
    property p_com;
        {common_analog_input_pos, common_analog_input_neg} ==
            {$past(positive_input_select) == 4'hC, $past(negative_input_select) == 4'hC};
    endproperty
    property p_ill;
        select_illegal == (bad($past(positive_input_select), $past(twelve_channel)) ||
                           bad($past(negative_input_select), $past(twelve_channel)));
    endproperty
    property p_por; s_wr_st ##1 s_rd_st |=> rd_data[7] == $past(req.wdata[7], 2); endproperty
    property p_rail;
        (!rail_monitor_enable)[*4] ##0 s_rd_st |=> rd_data[5:2] == 4'h0;
    endproperty
    property p_ref;
        (reference_monitor_enable == 2'b00)[*4] ##0 s_rd_st |=> rd_data[1:0] == 2'b00;
    endproperty
    property p_unmap; req.rd_en && req.addr > ADCSR_INSEL_ADDR |=> rd_data == 8'h00; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
    a_pos: assert property (p_pos) else $error("positive select wrong");
    a_neg: assert property (p_neg) else $error("negative select wrong");
    a_hold: assert property (p_hold) else $error("select changed");
    a_com: assert property (p_com) else $error("common flag wrong");
    a_ill: assert property (p_ill) else $error("illegal flag wrong");
    a_por: assert property (p_por) else $error("power-on flag wrong");
    a_rail: assert property (p_rail) else $error("rail flag not gated");
    a_ref: assert property (p_ref) else $error("reference flag not gated");
    a_unmap: assert property (p_unmap) else $error("unmapped read data");
endmodule // adcsr_regs_chk

bind adcsr_regs adcsr_regs_chk u_adcsr_regs_chk (.clk(clk), .rst_n(rst_n), .req(req),
    .rd_data(rd_data), .rd_valid(rd_valid), .rail_monitor_enable(rail_monitor_enable),
    .reference_monitor_enable(reference_monitor_enable), .twelve_channel(twelve_channel),
    .positive_input_select(positive_input_select),
    .negative_input_select(negative_input_select),
    .common_analog_input_pos(common_analog_input_pos),
    .common_analog_input_neg(common_analog_input_neg), .select_illegal(select_illegal));

// >>> adcsr_regs_tb.sv
`timescale 1ns/1ps
module adcsr_regs_tb;
    import adcsr_pkg::*;
    logic       clk, rst_n, rail_en, twelve, rd_valid, cp, cn, ill;
    logic [1:0] ref_en;
    logic [3:0] ps, ns;
    logic [7:0] rd_data, d;
    adcsr_mon_t mon;
    adcsr_req_t req;
    int         fail_count, comparisons, seed, i;
    logic [7:0] exp_q[$];
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    adcsr_host u_adcsr_host (.clk(clk), .req(req));
    adcsr_regs u_adcsr_regs (.clk(clk), .rst_n(rst_n), .req(req), .rd_data(rd_data),
        .rd_valid(rd_valid), .mon_async(mon), .rail_monitor_enable(rail_en),
        .reference_monitor_enable(ref_en), .twelve_channel(twelve), .positive_input_select(ps),
        .negative_input_select(ns), .common_analog_input_pos(cp), .common_analog_input_neg(cn),
        .select_illegal(ill));
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            fail_count++;
            $display("FAIL %s exp %h got %h", n, e, g);
        end
    endtask
    task rd(input logic [4:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_adcsr_host.op(0, 1, a, 0);
    endtask
    task idle(input int n);
        repeat (n) u_adcsr_host.op(0, 0, 0, 0);
    endtask
    function logic bad(logic [3:0] c);
        return c > 4'hC || (!twelve && c >= 4'h6 && c <= 4'hB);
    endfunction
    task close_out;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(negedge clk)
        if (rd_valid === 1'b1)
        begin
            if (exp_q.size() == 0) chk("rd_valid", 0, 1);
            else chk("rd_data", exp_q.pop_front(), rd_data);
        end
    initial begin
        #(50 * 2000);
        fail_count++;
        close_out;
    end
    initial begin
        seed = 32'hfe8ff796;
        {rst_n, rail_en, ref_en, twelve, mon} = {5'b00001, 7'h40};
        repeat (20) @(posedge clk);
        #1 rst_n = 1;
        rd(ADCSR_STATUS_ADDR, 8'h80);
        rd(ADCSR_INSEL_ADDR, 8'h01);
        rd(5'h03, 8'h00);
        u_adcsr_host.op(1, 0, ADCSR_STATUS_ADDR, 8'h7F);
        rd(ADCSR_STATUS_ADDR, 8'h00);
        u_adcsr_host.op(1, 0, ADCSR_STATUS_ADDR, 8'hFF);
        rd(ADCSR_STATUS_ADDR, 8'h80);
        u_adcsr_host.op(1, 0, ADCSR_STATUS_ADDR, 8'h00);
        {rail_en, ref_en} = 3'b111;
        for (i = 0; i < 7; i++)
        begin
            mon = 7'h40 ^ (7'h01 << i);
            idle(4);
            rd(ADCSR_STATUS_ADDR, 8'h01 << i);
        end
        {rail_en, ref_en, mon} = {3'b000, 7'h3F};
        idle(4);
        rd(ADCSR_STATUS_ADDR, 8'h40);
        ref_en = 2'b01;
        idle(4);
        rd(ADCSR_STATUS_ADDR, 8'h41);
        ref_en = 2'b10;
        idle(4);
        rd(ADCSR_STATUS_ADDR, 8'h43);
        for (i = 0; i < 16; i++)
        begin
            d = (i == 0) ? 8'hCD : 8'($random(seed));
            twelve = 1'($random(seed));
            u_adcsr_host.op(1, 0, ADCSR_INSEL_ADDR, d);
            u_adcsr_host.op(1, 0, 5'h1F, ~d);
            rd(ADCSR_INSEL_ADDR, d);
            idle(1);
            chk("select", d, {ps, ns});
            chk("flags", {5'h0, bad(d[7:4]) || bad(d[3:0]), d[7:4] == 4'hC, d[3:0] == 4'hC},
                {5'h0, ill, cp, cn});
        end
        idle(2);
        chk("pending", 8'h00, 8'(exp_q.size()));
        close_out;
    end
endmodule // adcsr_regs_tb

// >>> adcsr_sync.sv
`timescale 1ns/1ps
module adcsr_sync
    import adcsr_pkg::*;
#(
    parameter int         WIDTH = ADCSR_MON_W,
    parameter logic [6:0] INIT  = ADCSR_MON_RESET
)
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // ************************************************************
    // Two-stage synchroniser per bit
    // ************************************************************
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic stage1_reg;
            logic stage2_reg;
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    stage1_reg <= INIT[i];
                    stage2_reg <= INIT[i];
                end
                else
                begin
                    stage1_reg <= async_in[i];
                    stage2_reg <= stage1_reg;
                end
            end
            assign sync_out[i] = stage2_reg;
        end
    endgenerate

endmodule // adcsr_sync
